// file: rtl/dac_regs_pkg.sv
// constants for the converter control register bank
// assumes a 32-bit classic wishbone bus and a 16-bit register file
package dac_regs_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_NOP      = 6'h00;
	localparam logic [5:0] IDX_CODE     = 6'h01;
	localparam logic [5:0] IDX_GCFG     = 6'h02;
	localparam logic [5:0] IDX_DCFG     = 6'h03;
	localparam logic [5:0] IDX_GAIN     = 6'h04;
	localparam logic [5:0] IDX_OFFSET   = 6'h05;
	localparam logic [5:0] IDX_CLRCODE  = 6'h06;
	localparam logic [5:0] IDX_STATUS   = 6'h10;

	// reset values
	localparam logic [15:0] GCFG_RESET  = 16'h0036;
	localparam logic [15:0] DCFG_RESET  = 16'h0b00;
	localparam logic [15:0] GAIN_RESET  = 16'h8000;

	// writable bits; the rest read as their fixed value
	localparam logic [15:0] GCFG_WMASK  = 16'h7bdf;
	localparam logic [15:0] GCFG_FIXED  = 16'h0020;
	localparam logic [15:0] DCFG_WMASK  = 16'hfff7;

	// global configuration fields
	localparam int CRC_LIM_LO  = 13;
	localparam int CLOCK_OUT_DIVIDER    = 12;
	localparam int CLOCK_OUT_ENABLE     = 11;
	localparam int LINK_IRQ_EN = 9;
	localparam int IRQ_PIN_EN  = 8;
	localparam int CLEAR_PIN_ENABLE  = 7;
	localparam int UART_DISABLE    = 6;
	localparam int CRC_EN      = 4;
	localparam int INTERRUPT_POLARITY     = 3;
	localparam int INTERRUPT_LEVEL_SELECT     = 2;
	localparam int SDO_TRI     = 1;
	localparam int SDO_EARLY   = 0;

	// converter configuration fields
	localparam int PWR_DOWN    = 12;
	localparam int SLEW_CLK_LO = 9;
	localparam int SLEW_STP_LO = 6;
	localparam int SLEW_EN     = 5;
	localparam int SLEW_SHAPE  = 4;
	localparam int FORCE_CLR   = 2;
	localparam int CLR_SPAN    = 1;
	localparam int RUN_SPAN    = 0;

	// status fields
	localparam int ST_CRC_ERR  = 0;
	localparam int ST_CLEAR    = 1;

	// oscillator divider: bit 0 gives the base clock, this bit gives base/128
	localparam int CLOCK_OUT_DIVIDER_BIT = 7;
	// slew tick for code 0 is base/4, each code halves it
	localparam int SLEW_BASE_SHIFT = 3;
	// unity gain point of the gain word
	localparam logic [16:0] GAIN_UNITY = 17'h08000;
endpackage

// file: rtl/dac_control_register_bank.sv
// control register bank, clear logic, code path and slew engine of the converter
// assumes a classic wishbone master, an oscillator tick from the same clock,
// and frame/interrupt events from serial logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module dac_control_register_bank (
	// clock, reset, enable
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        CE_I,
	// wishbone slave
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	// events from neighbouring logic
	input  wire logic        OSC_TICK_I,
	input  wire logic        CRC_FRAME_DONE_I,
	input  wire logic        CRC_FRAME_BAD_I,
	input  wire logic        IRQ_EVENT_I,
	input  wire logic        UART_MODE_I,
	// pins
	input  wire logic        CLEAR_INPUT_PIN_I,
	input  wire logic        SERIAL_DATA_IN_I,
	input  wire logic        CS_N_I,
	output logic             CLOCK_OUTPUT_PIN_O,
	output logic             IRQ_PIN_O,
	output logic             SERIAL_OUT_OE_N_O,
	output logic             SERIAL_OUT_EARLY_LAUNCH_O,
	output logic             VOLTAGE_OUTPUT_OE_N_O,
	// controls to the serial and analog sections
	output logic             UART_ENABLE_O,
	output logic             UART_IRQ_REQUEST_O,
	output logic             CRC_CHECK_ENABLE_O,
	output logic             SPAN_SELECT_O,
	output logic      [15:0] DAC_CODE_O
);
	typedef struct packed {
		logic        ack;
		logic [15:0] rdata;
		logic [15:0] data;
		logic [15:0] gcfg;
		logic [15:0] dcfg;
		logic [15:0] gain;
		logic [15:0] ofs;
		logic [15:0] clrc;
		logic [15:0] code;
		logic [3:0]  crc_cnt;
		logic        crc_err;
		logic [9:0]  div;
		logic [2:0]  sync_clr;
		logic [2:0]  sync_sdi;
		logic [2:0]  sync_cs;
		logic        clr_lvl;
		logic        sdi_lvl;
		logic        cs_lvl;
		logic        irq_prev;
		logic        irq_pulse;
		logic        link_irq;
	} state_type;

	state_type s_reg;
	state_type s_next;

	logic        req;
	logic [5:0]  idx;
	logic        clear_state;
	logic [15:0] target;
	logic [32:0] prod;
	logic [18:0] sum;
	logic [10:0] slew_mask;
	logic        slew_tick;
	logic [15:0] step;

	// merge the low two byte lanes of a write
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	assign req = CYC_I && STB_I;
	assign idx = ADR_I[7:2];

	// clear state from the register bit or, when allowed, from the pin
	always_comb begin
		clear_state = s_reg.dcfg[dac_regs_pkg::FORCE_CLR];
		if (s_reg.gcfg[dac_regs_pkg::CLEAR_PIN_ENABLE]) begin
			clear_state = clear_state
				| (UART_MODE_I ? s_reg.sdi_lvl : s_reg.clr_lvl);
		end
	end

	// code path: gain in 0.5..1.5, signed offset, saturation, then clear override
	always_comb begin
		prod = 33'(s_reg.data) * 33'(dac_regs_pkg::GAIN_UNITY + 17'(s_reg.gain));
		sum  = {2'b00, prod[32:16]} + {{3{s_reg.ofs[15]}}, s_reg.ofs};
		if (sum[18]) begin
			target = 16'h0000;
		end else if (sum[17:16] != 2'b00) begin
			target = 16'hffff;
		end else begin
			target = sum[15:0];
		end
		if (clear_state) begin
			target = s_reg.clrc;
		end
	end

	// slew tick once per period of the selected oscillator division
	always_comb begin
		slew_mask = 11'((11'h001 << (dac_regs_pkg::SLEW_BASE_SHIFT
			+ int'(s_reg.dcfg[dac_regs_pkg::SLEW_CLK_LO +: 3]))) - 11'h001);
		slew_tick = OSC_TICK_I && ((11'(s_reg.div) & slew_mask) == slew_mask);
		step = 16'h0001 << s_reg.dcfg[dac_regs_pkg::SLEW_STP_LO +: 3];
	end

	// next-state logic for the whole block
	always_comb begin
		logic [15:0] diff;
		logic [15:0] st;
		logic [3:0]  lim;
		diff = 16'h0000;
		st = 16'h0000;
		lim = 4'h1 << s_reg.gcfg[dac_regs_pkg::CRC_LIM_LO +: 2];
		s_next = s_reg;

		// bus: one wait state, then ack for one cycle; writes land at the ack edge
		s_next.ack = req && !s_reg.ack;
		if (req && !s_reg.ack && !WE_I) begin
			unique case (idx)
				dac_regs_pkg::IDX_CODE:    s_next.rdata = s_reg.data;
				dac_regs_pkg::IDX_GCFG:    s_next.rdata = s_reg.gcfg;
				dac_regs_pkg::IDX_DCFG:    s_next.rdata = s_reg.dcfg;
				dac_regs_pkg::IDX_GAIN:    s_next.rdata = s_reg.gain;
				dac_regs_pkg::IDX_OFFSET:  s_next.rdata = s_reg.ofs;
				dac_regs_pkg::IDX_CLRCODE: s_next.rdata = s_reg.clrc;
				dac_regs_pkg::IDX_STATUS:  s_next.rdata = {14'h0000, clear_state, s_reg.crc_err};
				default:                   s_next.rdata = 16'h0000;
			endcase
		end else if (!req) begin
			s_next.rdata = 16'h0000;
		end

		// checksum frame counting; a set in the clear cycle wins below
		if (req && s_reg.ack && WE_I && idx == dac_regs_pkg::IDX_STATUS
			&& SEL_I[0] && DAT_I[dac_regs_pkg::ST_CRC_ERR]) begin
			s_next.crc_err = 1'b0;
		end
		if (CRC_FRAME_DONE_I && s_reg.gcfg[dac_regs_pkg::CRC_EN]) begin
			if (!CRC_FRAME_BAD_I) begin
				s_next.crc_cnt = 4'h0;
			end else if (s_reg.crc_cnt + 4'h1 >= lim) begin
				s_next.crc_cnt = 4'h0;
				s_next.crc_err = 1'b1;
			end else begin
				s_next.crc_cnt = s_reg.crc_cnt + 4'h1;
			end
		end

		// register writes; the no-op word and unmapped indices take nothing
		if (req && s_reg.ack && WE_I) begin
			unique case (idx)
				dac_regs_pkg::IDX_CODE:    s_next.data = merge(s_reg.data, DAT_I, SEL_I);
				dac_regs_pkg::IDX_GCFG:    s_next.gcfg = (merge(s_reg.gcfg, DAT_I, SEL_I)
					& dac_regs_pkg::GCFG_WMASK) | dac_regs_pkg::GCFG_FIXED;
				dac_regs_pkg::IDX_DCFG:    s_next.dcfg = merge(s_reg.dcfg, DAT_I, SEL_I)
					& dac_regs_pkg::DCFG_WMASK;
				dac_regs_pkg::IDX_GAIN:    s_next.gain = merge(s_reg.gain, DAT_I, SEL_I);
				dac_regs_pkg::IDX_OFFSET:  s_next.ofs  = merge(s_reg.ofs, DAT_I, SEL_I);
				dac_regs_pkg::IDX_CLRCODE: s_next.clrc = merge(s_reg.clrc, DAT_I, SEL_I);
				default:                   s_next.data = s_reg.data;
			endcase
		end

		// oscillator divider, free running on the tick
		if (OSC_TICK_I) begin
			s_next.div = s_reg.div + 10'h001;
		end

		// pin synchronisers; a level is taken once stages two and three agree
		s_next.sync_clr = {s_reg.sync_clr[1:0], CLEAR_INPUT_PIN_I};
		s_next.sync_sdi = {s_reg.sync_sdi[1:0], SERIAL_DATA_IN_I};
		s_next.sync_cs  = {s_reg.sync_cs[1:0], CS_N_I};
		if (s_reg.sync_clr[2] == s_reg.sync_clr[1]) begin
			s_next.clr_lvl = s_reg.sync_clr[2];
		end
		if (s_reg.sync_sdi[2] == s_reg.sync_sdi[1]) begin
			s_next.sdi_lvl = s_reg.sync_sdi[2];
		end
		if (s_reg.sync_cs[2] == s_reg.sync_cs[1]) begin
			s_next.cs_lvl = s_reg.sync_cs[2];
		end

		// interrupt event edge, used for edge mode and link notifications
		s_next.irq_prev  = IRQ_EVENT_I;
		s_next.irq_pulse = IRQ_EVENT_I && !s_reg.irq_prev;
		s_next.link_irq  = IRQ_EVENT_I && !s_reg.irq_prev
			&& s_reg.gcfg[dac_regs_pkg::LINK_IRQ_EN] && !s_reg.gcfg[dac_regs_pkg::UART_DISABLE];

		// output code: jump, or ramp toward the target on each slew tick
		if (!s_reg.dcfg[dac_regs_pkg::SLEW_EN]) begin
			s_next.code = target;
		end else if (slew_tick && s_reg.code != target) begin
			diff = (s_reg.code < target) ? target - s_reg.code : s_reg.code - target;
			st = step;
			// sine shape eases into the target by shrinking the step
			if (s_reg.dcfg[dac_regs_pkg::SLEW_SHAPE] && (diff >> 2) + 16'h0001 < st) begin
				st = (diff >> 2) + 16'h0001;
			end
			if (st > diff) begin
				st = diff;
			end
			s_next.code = (s_reg.code < target) ? s_reg.code + st : s_reg.code - st;
		end
	end

	// all state in one register; the enable freezes everything
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			s_reg          <= '0;
			s_reg.gcfg     <= dac_regs_pkg::GCFG_RESET;
			s_reg.dcfg     <= dac_regs_pkg::DCFG_RESET;
			s_reg.gain     <= dac_regs_pkg::GAIN_RESET;
			s_reg.sync_cs  <= 3'h7;
			s_reg.cs_lvl   <= 1'b1;
		end else if (CE_I) begin
			s_reg <= s_next;
		end
	end

	// bus outputs
	assign ACK_O = s_reg.ack;
	assign DAT_O = {16'h0000, s_reg.rdata};

	// pin and control outputs
	always_comb begin
		logic active;
		active = s_reg.gcfg[dac_regs_pkg::INTERRUPT_LEVEL_SELECT] ? s_reg.irq_prev : s_reg.irq_pulse;
		active = active && s_reg.gcfg[dac_regs_pkg::IRQ_PIN_EN];
		IRQ_PIN_O = s_reg.gcfg[dac_regs_pkg::INTERRUPT_POLARITY] ? active : !active;
		CLOCK_OUTPUT_PIN_O = s_reg.gcfg[dac_regs_pkg::CLOCK_OUT_ENABLE]
			&& (s_reg.gcfg[dac_regs_pkg::CLOCK_OUT_DIVIDER] ? s_reg.div[dac_regs_pkg::CLOCK_OUT_DIVIDER_BIT]
			: s_reg.div[0]);
		SERIAL_OUT_OE_N_O = s_reg.gcfg[dac_regs_pkg::SDO_TRI] || s_reg.cs_lvl;
		SERIAL_OUT_EARLY_LAUNCH_O = s_reg.gcfg[dac_regs_pkg::SDO_EARLY];
		VOLTAGE_OUTPUT_OE_N_O = s_reg.dcfg[dac_regs_pkg::PWR_DOWN];
		UART_ENABLE_O = !s_reg.gcfg[dac_regs_pkg::UART_DISABLE];
		UART_IRQ_REQUEST_O = s_reg.link_irq;
		CRC_CHECK_ENABLE_O = s_reg.gcfg[dac_regs_pkg::CRC_EN];
		SPAN_SELECT_O = clear_state ? s_reg.dcfg[dac_regs_pkg::CLR_SPAN]
			: s_reg.dcfg[dac_regs_pkg::RUN_SPAN];
		DAC_CODE_O = s_reg.code;
	end

	// checks
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	nop_read_a: assert property (ACK_O && !WE_I && idx == dac_regs_pkg::IDX_NOP |-> DAT_O == 0)
		else $error("no-op word read not zero");
	bus_ack_a: assert property (CE_I && req && !ACK_O |=> ACK_O ##1 !ACK_O || !CE_I)
		else $error("ack not one cycle after request");
	crc_set_a: assert property (CE_I && $rose(s_reg.crc_err) |-> $past(CRC_FRAME_BAD_I
		&& CRC_FRAME_DONE_I && s_reg.gcfg[dac_regs_pkg::CRC_EN]))
		else $error("checksum error set without an errored frame");
	clk_off_a: assert property (!s_reg.gcfg[dac_regs_pkg::CLOCK_OUT_ENABLE] |-> !CLOCK_OUTPUT_PIN_O)
		else $error("clock output active while disabled");
	irq_idle_a: assert property (!s_reg.gcfg[dac_regs_pkg::IRQ_PIN_EN]
		|-> IRQ_PIN_O == !s_reg.gcfg[dac_regs_pkg::INTERRUPT_POLARITY])
		else $error("interrupt pin active while disabled");
	link_irq_a: assert property (UART_IRQ_REQUEST_O |-> UART_ENABLE_O
		&& $past(s_reg.gcfg[dac_regs_pkg::LINK_IRQ_EN]))
		else $error("link notification while not enabled");
	sdo_tri_a: assert property (s_reg.gcfg[dac_regs_pkg::SDO_TRI] |-> SERIAL_OUT_OE_N_O)
		else $error("serial output driven while tristated");
	clr_code_a: assert property (CE_I && s_reg.dcfg[dac_regs_pkg::FORCE_CLR]
		&& !s_reg.dcfg[dac_regs_pkg::SLEW_EN] |=> DAC_CODE_O == $past(s_reg.clrc) || !CE_I)
		else $error("clear code not applied");
	span_sel_a: assert property (clear_state |-> SPAN_SELECT_O == s_reg.dcfg[dac_regs_pkg::CLR_SPAN])
		else $error("wrong span in clear state");
	slew_step_a: assert property (CE_I && s_reg.dcfg[dac_regs_pkg::SLEW_EN] && !slew_tick
		|=> $stable(DAC_CODE_O) || !CE_I)
		else $error("code moved between slew ticks");

	crc_err_c: cover property ($rose(s_reg.crc_err));
	clear_c: cover property ($rose(clear_state));
	slew_c: cover property (s_reg.dcfg[dac_regs_pkg::SLEW_EN] ##1 $changed(DAC_CODE_O));
	write_c: cover property (req && WE_I && ACK_O);
endmodule // dac_control_register_bank
`default_nettype wire

// file: sim/serial_side_model.sv
// neighbour model: oscillator tick, serial frame ends and an interrupt source
// assumes the bank's clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module serial_side_model (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// events toward the bank
	output logic      tick_o,
	output logic      done_o,
	output logic      bad_o,
	output logic      irq_o
);
	logic [3:0] div_reg;

	// tick every 16 cycles, near twice the base rate at 40 mhz
	always_ff @(posedge clk_i) begin
		div_reg <= rst_i ? 4'h0 : div_reg + 4'h1;
		tick_o <= !rst_i && div_reg == 4'hf;
	end

	// idle until the bench asks for an event
	initial begin
		done_o = 1'b0;
		bad_o = 1'b0;
		irq_o = 1'b0;
	end

	// one frame end, bad marks a checksum error; returns after the pulse
	task automatic frame(input logic b);
		@(posedge clk_i);
		done_o <= 1'b1;
		bad_o <= b;
		@(posedge clk_i);
		done_o <= 1'b0;
		bad_o <= 1'b0;
	endtask

	// level of the interrupt source
	task automatic irq(input logic v);
		@(posedge clk_i);
		irq_o <= v;
	endtask
endmodule // serial_side_model
`default_nettype wire

// file: sim/test_dac_control_register_bank.sv
// self-checking bench for the converter control register bank
// assumes serial_side_model beside it and the wishbone timing of the hand-over
`timescale 1ns/1ps
`default_nettype none
module test_dac_control_register_bank;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, dat_o;
	logic clr_pin = 1'b0, sdi = 1'b0, cs_n = 1'b1, uart_mode = 1'b0, ce = 1'b1;
	logic [3:0] lane = 4'h3;
	logic ack, tick, done, bad, irq_ev, clock_output_pin, clock_output_pin_q, irq_pin, oe_n;
	logic early, voltage_output_oe_n, uart_en, uirq, crc_en, span;
	logic [15:0] code, v;
	logic [15:0] exp_q[$];
	logic [19:0] t;
	int n_fail = 0, checks_done = 0, cyc_cnt = 0, n_uirq = 0, n_tog = 0, u0;
	logic [15:0] rv [8] = '{16'h0, 16'h0, 16'h0036, 16'h0b00, 16'h8000, 16'h0, 16'h0, 16'h0};
	logic [63:0] ctab [7] = '{64'h1234_8000_0000_1234, 64'h1234_8000_ffff_1233,
		64'h1234_0000_0000_091a, 64'h8000_ffff_0000_bfff, 64'h ffff_ffff_0001_ffff,
		64'h0000_8000_ffff_0000, 64'h0000_8000_0000_0000};
	// {config, pin level in first cycle, pin level later, pin level idle, link requests}
	logic [19:0] itab [6] = '{20'h013ec, 20'h013a8, 20'h01362, 20'h003e0, 20'h0236f, 20'h0276e};

	always #12.5 clk = ~clk;

	dac_control_register_bank dut (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .CYC_I(cyc),
		.STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o),
		.ACK_O(ack), .OSC_TICK_I(tick), .CRC_FRAME_DONE_I(done), .CRC_FRAME_BAD_I(bad),
		.IRQ_EVENT_I(irq_ev), .UART_MODE_I(uart_mode), .CLEAR_INPUT_PIN_I(clr_pin),
		.SERIAL_DATA_IN_I(sdi), .CS_N_I(cs_n), .CLOCK_OUTPUT_PIN_O(clock_output_pin), .IRQ_PIN_O(irq_pin),
		.SERIAL_OUT_OE_N_O(oe_n), .SERIAL_OUT_EARLY_LAUNCH_O(early),
		.VOLTAGE_OUTPUT_OE_N_O(voltage_output_oe_n), .UART_ENABLE_O(uart_en),
		.UART_IRQ_REQUEST_O(uirq), .CRC_CHECK_ENABLE_O(crc_en), .SPAN_SELECT_O(span),
		.DAC_CODE_O(code));

	serial_side_model peer (.clk_i(clk), .rst_i(rst), .tick_o(tick), .done_o(done),
		.bad_o(bad), .irq_o(irq_ev));

	task automatic final_report;
		if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle; a read leaves its expected word for the watcher
	task automatic wb(input logic w, input logic [5:0] i, input logic [15:0] d,
		input logic [15:0] e);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		sel <= lane;
		// the upper half is ignored by the bank, so random bits there must not matter
		dat <= {16'($urandom), d};
		if (!w) exp_q.push_back(e);
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// settle past the edge so registered outputs have landed
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// watcher: read data at the ack edge, link requests, clock pin toggles, hang limit
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) compare(dat_o, {16'h0, exp_q.pop_front()});
		if (uirq === 1'b1) n_uirq++;
		if (clock_output_pin !== clock_output_pin_q) n_tog++;
		clock_output_pin_q <= clock_output_pin;
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			n_fail++;
			final_report();
		end
	end

	initial begin
		void'($urandom(34643));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 8; k++) wb(0, 6'(k), 16'h0, rv[k]);
		compare(32'({clock_output_pin, irq_pin, oe_n, voltage_output_oe_n, uart_en, crc_en, span, early}), 32'h6c);
		// writes to the no-op word and an unmapped index vanish
		wb(1, 6'h00, 16'hffff, 16'h0);
		wb(1, 6'h07, 16'hffff, 16'h0);
		wb(0, 6'h00, 16'h0, 16'h0);
		wb(0, 6'h07, 16'h0, 16'h0);
		// reserved bits hold their fixed value whatever is written
		wb(1, 6'h02, 16'h0000, 16'h0);
		wb(0, 6'h02, 16'h0, 16'h0020);
		compare(32'({uart_en, early, oe_n, crc_en}), 32'ha);
		wb(1, 6'h02, 16'hffff, 16'h0);
		wb(0, 6'h02, 16'h0, 16'h7bff);
		compare(32'({uart_en, early, oe_n, crc_en}), 32'h7);
		for (int k = 1; k < 7; k++) if (k != 2) begin
			v = 16'($urandom);
			wb(1, 6'(k), v, 16'h0);
			wb(0, 6'(k), 16'h0, k == 3 ? v & 16'hfff7 : v);
		end
		// code path: data, gain, offset, applied code, slew off
		wb(1, 6'h03, 16'h0b00, 16'h0);
		for (int k = 0; k < 7; k++) begin
			wb(1, 6'h01, ctab[k][63:48], 16'h0);
			wb(1, 6'h04, ctab[k][47:32], 16'h0);
			wb(1, 6'h05, ctab[k][31:16], 16'h0);
			wait_n(2);
			compare(32'(code), 32'(ctab[k][15:0]));
		end
		// slew: fastest clock, 128-code steps, so a jump of 256 takes two steps
		wb(1, 6'h03, 16'h01e0, 16'h0);
		wb(1, 6'h01, 16'h0100, 16'h0);
		wait_n(2);
		compare(32'(code < 16'h0100), 32'h1);
		wait_n(600);
		compare(32'(code), 32'h0100);
		// clear state by bit, then by pin in both serial modes
		wb(1, 6'h06, 16'h5a5a, 16'h0);
		wb(1, 6'h03, 16'h0b06, 16'h0);
		wait_n(2);
		compare(32'({span, code}), 32'h15a5a);
		wb(0, 6'h10, 16'h0, 16'h0002);
		wb(1, 6'h03, 16'h0b01, 16'h0);
		wait_n(2);
		compare(32'({span, code}), 32'h10100);
		wb(1, 6'h03, 16'h0b00, 16'h0);
		wb(1, 6'h02, 16'h00b6, 16'h0);
		@(posedge clk);
		clr_pin <= 1'b1;
		wait_n(6);
		compare(32'(code), 32'h5a5a);
		@(posedge clk);
		clr_pin <= 1'b0;
		uart_mode <= 1'b1;
		sdi <= 1'b1;
		wait_n(6);
		compare(32'(code), 32'h5a5a);
		@(posedge clk);
		sdi <= 1'b0;
		uart_mode <= 1'b0;
		wait_n(6);
		compare(32'(code), 32'h0100);
		wb(1, 6'h03, 16'h1b00, 16'h0);
		wait_n(1);
		compare(32'(voltage_output_oe_n), 32'h1);
		// a low-lane-only write keeps the high byte
		lane = 4'h1;
		wb(1, 6'h06, 16'hffff, 16'h0);
		lane = 4'h3;
		wb(0, 6'h06, 16'h0, 16'h5aff);
		wb(1, 6'h06, 16'h5a5a, 16'h0);
		// serial output driven only while selected; a low enable freezes the bank
		wb(1, 6'h02, 16'h0034, 16'h0);
		@(posedge clk);
		ce <= 1'b0;
		cs_n <= 1'b0;
		wait_n(6);
		compare(32'(oe_n), 32'h1);
		@(posedge clk);
		ce <= 1'b1;
		wait_n(6);
		compare(32'(oe_n), 32'h0);
		@(posedge clk);
		cs_n <= 1'b1;
		wait_n(6);
		compare(32'(oe_n), 32'h1);
		// every error limit, with a good frame restarting the run
		for (int l = 0; l < 4; l++) begin
			wb(1, 6'h02, 16'h0036 | 16'(l << 13), 16'h0);
			peer.frame(1'b0);
			repeat ((1 << l) - 1) peer.frame(1'b1);
			peer.frame(1'b0);
			repeat ((1 << l) - 1) peer.frame(1'b1);
			wb(0, 6'h10, 16'h0, 16'h0000);
			peer.frame(1'b1);
			wb(0, 6'h10, 16'h0, 16'h0001);
			wb(1, 6'h10, 16'h0001, 16'h0);
		end
		wb(1, 6'h02, 16'h0026, 16'h0);
		peer.frame(1'b1);
		wb(0, 6'h10, 16'h0, 16'h0000);
		// interrupt pin polarity, level or edge, and link requests
		for (int k = 0; k < 6; k++) begin
			t = itab[k];
			wb(1, 6'h02, t[19:4], 16'h0);
			u0 = n_uirq;
			peer.irq(1'b1);
			wait_n(1);
			compare(32'(irq_pin), 32'(t[3]));
			wait_n(3);
			compare(32'(irq_pin), 32'(t[2]));
			peer.irq(1'b0);
			wait_n(3);
			compare(32'(irq_pin), 32'(t[1]));
			compare(32'(n_uirq - u0), 32'(t[0]));
		end
		// clock output: base rate, divided rate, disabled
		for (int k = 0; k < 3; k++) begin
			wb(1, 6'h02, k == 0 ? 16'h0836 : (k == 1 ? 16'h1836 : 16'h1036), 16'h0);
			u0 = n_tog;
			wait_n(512);
			compare(32'(k == 0 ? n_tog - u0 >= 16 : n_tog - u0 <= 1), 32'h1);
		end
		compare(32'(clock_output_pin), 32'h0);
		final_report();
	end
endmodule // test_dac_control_register_bank
`default_nettype wire
